// File: hw/wgt_top.sv
// Windowed guard timer: registers, feed sequencer, counter, reset and interrupt
//
// Function
// [RULE1] Counter running out without a reload resets the whole chip. The code resets only with mode_rst_en set, else sets time-out status.
// [RULE2] In windowed use a feed counts only between minimum and maximum time.
// [RULE3] Warning interrupt when the counter reaches a programmed point.
// [RULE4] Software can set the enable but never clear it.
// [RULE5] A malformed feed sequence resets the chip, or interrupts if reset is off.
// [RULE6] A flag records that the last chip reset came from the timer.
// [RULE7] A 24-bit down counter behind a fixed divide-by-four prescaler.
// [RULE8] Period spans 256 times four up to 2^24 times four clock periods.
// [RULE9] Software selects the internal RC oscillator or the guard oscillator.
// [RULE10] In deep sleep the RC oscillator stays on only if selected here.
// [RULE11] A timer interrupt wakes the chip from deep sleep and power-down.
// [RULE12] Two fixed feed writes; the counter reloads after the second.
module wgt_top
  import wgt_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  input  wire logic        irc_tick,
  input  wire logic        osc_tick,
  input  wire logic        deep_sleep,
  input  wire logic        power_down,
  output logic             irq,
  output logic             chip_rst_req,
  output logic             irc_keep_on,
  output logic             wake_req
);

  // ==========================================================================
  // Parameter check
  initial begin
    if (CNT_W != 24) begin
      $error("wgt_top: CNT_W must be 24");
    end
  end

  // ==========================================================================
  // Declarations
  logic                 mode_en;
  logic                 mode_rst_en;
  logic                 clk_src;
  logic [CNT_W-1:0]     tc;
  logic [CNT_W-1:0]     warn;
  logic [CNT_W-1:0]     win;
  logic [CNT_W-1:0]     cnt;
  logic [STAT_W-1:0]    status;
  logic [STAT_W-1:0]    mask;
  logic                 wd_rst_flag;
  wgt_feed_state_t      feed_state;
  logic                 wr_mode;
  logic                 wr_tc;
  logic                 wr_feed;
  logic                 wr_clksel;
  logic                 wr_warn;
  logic                 wr_win;
  logic                 wr_status;
  logic                 wr_mask;
  logic                 wr_rstflg;
  logic                 feed_ok;
  logic                 feed_bad;
  logic                 win_err;
  logic                 feed_good;
  logic                 fault;
  logic                 src_tick;
  logic                 tick;
  logic                 timeout;
  logic                 warn_hit;
  logic                 wd_event;
  logic [STAT_W-1:0]    stat_set;
  logic [CNT_W-1:0]     next_tc;

  // ==========================================================================
  // Write decode
  assign wr_mode   = wr_en && (addr == OFF_MODE);
  assign wr_tc     = wr_en && (addr == OFF_TC);
  assign wr_feed   = wr_en && (addr == OFF_FEED);
  assign wr_clksel = wr_en && (addr == OFF_CLKSEL);
  assign wr_warn   = wr_en && (addr == OFF_WARN);
  assign wr_win    = wr_en && (addr == OFF_WINDOW);
  assign wr_status = wr_en && (addr == OFF_STATUS);
  assign wr_mask   = wr_en && (addr == OFF_MASK);
  assign wr_rstflg = wr_en && (addr == OFF_RSTFLG);

  // ==========================================================================
  // Feed sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      feed_state <= WGT_FEED_IDLE;
    end else begin
      case (feed_state)
        WGT_FEED_IDLE: begin
          if (wr_feed && (wdata == FEED_FIRST)) begin
            feed_state <= WGT_FEED_ARMED;
          end
        end
        WGT_FEED_ARMED: begin
          if (wr_en) begin
            feed_state <= WGT_FEED_IDLE;
          end
        end
        default: begin
          feed_state <= WGT_FEED_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    feed_ok  = 1'b0;
    feed_bad = 1'b0;
    case (feed_state)
      WGT_FEED_IDLE: begin
        feed_bad = wr_feed && (wdata != FEED_FIRST); // RULE5
      end
      WGT_FEED_ARMED: begin
        feed_ok  = wr_feed && (wdata == FEED_SECOND); // RULE12
        feed_bad = wr_en && !feed_ok; // RULE5
      end
      default: begin
        feed_bad = 1'b0;
      end
    endcase
  end

  // Reload allowed only once the counter has dropped to the window value
  assign win_err   = feed_ok && (cnt > win); // RULE2
  assign feed_good = feed_ok && !win_err; // RULE12
  assign fault     = mode_en && (feed_bad || win_err); // RULE5

  // ==========================================================================
  // Clock source and prescaler
  assign src_tick = clk_src ? osc_tick : irc_tick; // RULE9

  wgt_prescaler #(
    .DIV (PRESC_DIV)
  ) u_presc (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clr      (!mode_en),
    .tick_in  (src_tick),
    .tick_out (tick)
  ); // RULE7

  // ==========================================================================
  // Counter and events
  assign timeout  = mode_en && tick && (cnt == '0); // RULE1
  assign warn_hit = mode_en && tick && (cnt == warn) && (cnt != '0); // RULE3
  assign wd_event = timeout || fault;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= TC_RESET;
    end else if (feed_good || timeout) begin
      cnt <= tc; // RULE12
    end else if (mode_en && tick) begin
      cnt <= cnt - CNT_W'(1); // RULE7
    end
  end

  // ==========================================================================
  // Mode and clock select registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_en <= 1'b0;
    end else if (wd_event) begin
      mode_en <= 1'b0; // RULE4
    end else if (wr_mode && wdata[MODE_EN_BIT]) begin
      mode_en <= 1'b1; // RULE4
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_rst_en <= 1'b0;
    end else if (wr_mode) begin
      mode_rst_en <= wdata[MODE_RSTEN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_src <= 1'b0;
    end else if (wr_clksel) begin
      clk_src <= wdata[0]; // RULE9
    end
  end

  // ==========================================================================
  // Time-out, warning and window values
  always_comb begin
    next_tc = wdata[CNT_W-1:0];
    if (next_tc < TC_MIN) begin
      next_tc = TC_MIN; // RULE8
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tc <= TC_RESET;
    end else if (wr_tc) begin
      tc <= next_tc; // RULE8
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      warn <= WARN_RESET;
    end else if (wr_warn) begin
      warn <= wdata[CNT_W-1:0]; // RULE3
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win <= WIN_RESET;
    end else if (wr_win) begin
      win <= wdata[CNT_W-1:0]; // RULE2
    end
  end

  // ==========================================================================
  // Chip reset request and its flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chip_rst_req <= 1'b0;
    end else if (wd_event && mode_rst_en) begin
      chip_rst_req <= 1'b1; // RULE1 RULE5
    end
  end

  // Kept across the chip reset; cleared only by power-on or by writing 1 to bit 0
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      wd_rst_flag <= 1'b0;
    end else if (chip_rst_req) begin
      wd_rst_flag <= 1'b1; // RULE6
    end else if (wr_rstflg && wdata[0]) begin
      wd_rst_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  always_comb begin
    stat_set               = '0;
    stat_set[STAT_TIMEOUT] = timeout && !mode_rst_en;
    stat_set[STAT_WARN]    = warn_hit; // RULE3
    stat_set[STAT_FEEDERR] = fault && !mode_rst_en; // RULE5
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= stat_set | (status & ~(wr_status ? wdata[STAT_W-1:0] : '0));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= wdata[STAT_W-1:0];
    end
  end

  assign irq = |(status & mask);

  // ==========================================================================
  // Power hooks
  assign irc_keep_on = !deep_sleep || !clk_src; // RULE10
  assign wake_req    = irq && (deep_sleep || power_down); // RULE11

  // ==========================================================================
  // Read port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        OFF_MODE:   rdata <= {30'h0, mode_rst_en, mode_en};
        OFF_TC:     rdata <= {8'h00, tc};
        OFF_TV:     rdata <= {8'h00, cnt};
        OFF_CLKSEL: rdata <= {31'h0, clk_src};
        OFF_WARN:   rdata <= {8'h00, warn};
        OFF_WINDOW: rdata <= {8'h00, win};
        OFF_STATUS: rdata <= {29'h0, status};
        OFF_MASK:   rdata <= {29'h0, mask};
        OFF_RSTFLG: rdata <= {31'h0, wd_rst_flag};
        default:    rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_reset_on_timeout: assert property ( // RULE1
    timeout && mode_rst_en |=> chip_rst_req)
    else $error("time-out did not request chip reset");

  a_window_early_feed: assert property ( // RULE2
    feed_ok && (cnt > win) && mode_en && !mode_rst_en |=> status[STAT_FEEDERR] && !mode_en)
    else $error("early feed not flagged");

  a_warn_raise: assert property ( // RULE3
    warn_hit && !feed_good |=> status[STAT_WARN] && (cnt == $past(warn) - 24'h00_0001))
    else $error("warning not raised at warning point");

  a_enable_sticky: assert property ( // RULE4
    mode_en && !wd_event |=> mode_en)
    else $error("enable dropped without watchdog event");

  a_bad_feed_reset: assert property ( // RULE5
    fault && mode_rst_en |=> chip_rst_req ##1 chip_rst_req)
    else $error("bad feed did not hold chip reset");

  a_flag_follows: assert property ( // RULE6
    $rose(chip_rst_req) |=> wd_rst_flag)
    else $error("reset flag not set");

  a_count_step: assert property ( // RULE7
    mode_en && tick && (cnt != '0) && !feed_good |=> cnt == $past(cnt) - 24'h00_0001)
    else $error("counter did not step by one");

  a_tick_spacing: assert property ( // RULE7
    tick |=> !tick [*3])
    else $error("prescaler ticks closer than four cycles");

  a_tc_floor: assert property ( // RULE8
    tc >= TC_MIN)
    else $error("time-out value below floor");

  a_irc_keep: assert property ( // RULE10
    deep_sleep && clk_src |-> !irc_keep_on)
    else $error("rc oscillator kept on while unselected");

  a_wake_on_irq: assert property ( // RULE11
    $rose(irq) && power_down |-> wake_req)
    else $error("interrupt did not wake");

  a_feed_reload: assert property ( // RULE12
    feed_good |=> (cnt == $past(tc)) && (feed_state == WGT_FEED_IDLE))
    else $error("feed did not reload counter");

endmodule

// File: hw/wgt_pkg.sv
// Package: register map, field positions, reset values and codes of the guard timer
package wgt_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_TC     = 8'h04;
  localparam logic [7:0] OFF_FEED   = 8'h08;
  localparam logic [7:0] OFF_TV     = 8'h0C;
  localparam logic [7:0] OFF_CLKSEL = 8'h10;
  localparam logic [7:0] OFF_WARN   = 8'h14;
  localparam logic [7:0] OFF_WINDOW = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MASK   = 8'h20;
  localparam logic [7:0] OFF_RSTFLG = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int MODE_EN_BIT    = 0;
  localparam int MODE_RSTEN_BIT = 1;
  localparam int STAT_TIMEOUT   = 0;
  localparam int STAT_WARN      = 1;
  localparam int STAT_FEEDERR   = 2;
  localparam int STAT_W         = 3;

  // ==========================================================================
  // Reset values and codes
  localparam logic [23:0] TC_MIN      = 24'h00_00FF;
  localparam logic [23:0] TC_RESET    = 24'h00_00FF;
  localparam logic [23:0] WARN_RESET  = 24'h00_0000;
  localparam logic [23:0] WIN_RESET   = 24'hFF_FFFF;
  localparam logic [31:0] FEED_FIRST  = 32'h0000_00AA;
  localparam logic [31:0] FEED_SECOND = 32'h0000_0055;
  localparam int          PRESC_DIV   = 4;

  // ==========================================================================
  // Feed sequencer states
  typedef enum logic [0:0] {
    WGT_FEED_IDLE,
    WGT_FEED_ARMED
  } wgt_feed_state_t;

endpackage

// File: hw/wgt_prescaler.sv
// Fixed divider between the guard timer clock ticks and the down counter
module wgt_prescaler #(
  parameter int DIV = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clr,
  input  wire logic tick_in,
  output logic      tick_out
);

  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

  logic [CW-1:0] phase;

  // ==========================================================================
  // Parameter check
  initial begin
    if (DIV < 2) begin
      $error("wgt_prescaler: DIV must be at least 2");
    end
  end

  // ==========================================================================
  // Divider
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (clr) begin
      phase <= '0;
    end else if (tick_in) begin
      if (phase == CW'(DIV - 1)) begin
        phase <= '0;
      end else begin
        phase <= phase + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= !clr && tick_in && (phase == CW'(DIV - 1));
    end
  end

endmodule

// File: verif/wgt_top_tb.sv
// Self-checking testbench of the windowed guard timer
module wgt_top_tb
  import wgt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic        clk_sys      = 1'b0;
  logic        rst_n        = 1'b0;
  logic        por_n        = 1'b0;
  logic [7:0]  addr         = 8'h00;
  logic [31:0] wdata        = 32'h0000_0000;
  logic        wr_en        = 1'b0;
  logic        rd_en        = 1'b0;
  logic        irc_tick     = 1'b0;
  logic        osc_tick     = 1'b0;
  logic        deep_sleep   = 1'b0;
  logic        power_down   = 1'b0;
  logic        run_irc      = 1'b0;
  logic        run_osc      = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic        chip_rst_req;
  logic        irc_keep_on;
  logic        wake_req;
  logic [31:0] seed         = 32'h0001_295A;
  logic [31:0] rv;
  int          n;
  int          error_cnt    = 0;
  int          total_checks = 0;
  logic [31:0] rst_exp [10] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000,
                                32'h0000_0000, 32'h00FF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  always #12.5 clk_sys = ~clk_sys;

  // Tick sources, one pulse per clock while running
  always @(posedge clk_sys) begin
    irc_tick <= run_irc;
    osc_tick <= run_osc;
  end

  wgt_top #(.CNT_W(24)) i_dut (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .por_n        (por_n),
    .addr         (addr),
    .wdata        (wdata),
    .wr_en        (wr_en),
    .rd_en        (rd_en),
    .rdata        (rdata),
    .irc_tick     (irc_tick),
    .osc_tick     (osc_tick),
    .deep_sleep   (deep_sleep),
    .power_down   (power_down),
    .irq          (irq),
    .chip_rst_req (chip_rst_req),
    .irc_keep_on  (irc_keep_on),
    .wake_req     (wake_req)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] exp_tc(input logic [31:0] v);
    return (v[23:0] < TC_MIN) ? {8'h00, TC_MIN} : {8'h00, v[23:0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic wait_hi(input bit sel, input int lim);
    n = 0;
    while ((sel ? chip_rst_req : irq) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n   <= 1'b0;
    run_irc <= 1'b0;
    run_osc <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic results();
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(60000 * 25);
    error_cnt++;
    results();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd_chk("reset value", 8'(i * 4), rst_exp[i]);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    wr(OFF_TV, 32'h0000_1234);
    rd_chk("tv read only", OFF_TV, 32'h0000_00FF);
    wr(OFF_TC, 32'h0000_00FE);
    rd_chk("tc floor", OFF_TC, 32'h0000_00FF);
    wr(OFF_MODE, 32'h0000_0001);
    wr(OFF_MODE, 32'h0000_0000);
    rd_chk("enable sticky", OFF_MODE, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(OFF_TC, seed);
      rd_chk("tc", OFF_TC, exp_tc(seed));
      seed = xs(seed);
      wr(OFF_WARN, seed);
      rd_chk("warn", OFF_WARN, {8'h00, seed[23:0]});
    end
    // Timeout raising the interrupt
    do_reset();
    wr(OFF_MASK, 32'h0000_0001);
    run_irc <= 1'b1;
    wr(OFF_MODE, 32'h0000_0001);
    wait_hi(0, 1200);
    chk("period", 32'h0000_0001, 32'(n >= 1020 && n <= 1032));
    chk_pin("chip_rst_req", 1'b0, chip_rst_req);
    rd_chk("status timeout", OFF_STATUS, 32'h0000_0001);
    rd_chk("enable off", OFF_MODE, 32'h0000_0000);
    wr(OFF_STATUS, 32'h0000_0001);
    #1 chk_pin("irq cleared", 1'b0, irq);
    // Warning and sleep outputs
    do_reset();
    wr(OFF_WARN, 32'h0000_00F0);
    wr(OFF_MASK, 32'h0000_0002);
    run_irc <= 1'b1;
    wr(OFF_MODE, 32'h0000_0001);
    wait_hi(0, 200);
    run_irc <= 1'b0;
    chk("warn time", 32'h0000_0001, 32'(n >= 56 && n <= 70));
    rd_chk("status warn", OFF_STATUS, 32'h0000_0002);
    @(posedge clk_sys);
    deep_sleep <= 1'b1;
    @(posedge clk_sys);
    #1 chk_pin("wake deep", 1'b1, wake_req);
    chk_pin("irc on", 1'b1, irc_keep_on);
    wr(OFF_CLKSEL, 32'h0000_0001);
    #1 chk_pin("irc off", 1'b0, irc_keep_on);
    @(posedge clk_sys);
    deep_sleep <= 1'b0;
    power_down <= 1'b1;
    @(posedge clk_sys);
    #1 chk_pin("wake pd", 1'b1, wake_req);
    wr(OFF_STATUS, 32'h0000_0007);
    #1 chk_pin("no wake", 1'b0, wake_req);
    @(posedge clk_sys);
    power_down <= 1'b0;
    // Clock source selection and feed
    do_reset();
    wr(OFF_CLKSEL, 32'h0000_0001);
    run_irc <= 1'b1;
    wr(OFF_MODE, 32'h0000_0001);
    repeat (40) @(posedge clk_sys);
    run_irc <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd_chk("tv held", OFF_TV, 32'h0000_00FF);
    run_osc <= 1'b1;
    repeat (40) @(posedge clk_sys);
    run_osc <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(OFF_TV, rv);
    chk("osc count", 32'h0000_0001, 32'((32'h0000_00FF - rv) inside {[8:10]}));
    wr(OFF_FEED, FEED_FIRST);
    wr(OFF_FEED, FEED_SECOND);
    rd_chk("tv reload", OFF_TV, 32'h0000_00FF);
    // Malformed feeds and window boundary
    for (int k = 0; k < 4; k++) begin
      do_reset();
      power_down <= 1'b1;
      wr(OFF_MASK, 32'h0000_0004);
      wr(OFF_WINDOW, (k == 2) ? 32'h0000_00FE : 32'h0000_00FF);
      wr(OFF_MODE, 32'h0000_0001);
      if (k > 0) wr(OFF_FEED, FEED_FIRST);
      wr(OFF_FEED, (k == 0) ? 32'h0000_0012 : (k == 1) ? 32'h0000_0033 : FEED_SECOND);
      rd_chk("feed status", OFF_STATUS, (k == 3) ? 32'h0000_0000 : 32'h0000_0004);
      rd_chk("mode after feed", OFF_MODE, 32'(k == 3));
      chk_pin("feed irq", k != 3, irq);
      chk_pin("feed wake", k != 3, wake_req);
    end
    // Chip reset and its flag
    do_reset();
    power_down <= 1'b0;
    run_irc <= 1'b1;
    wr(OFF_MODE, 32'h0000_0003);
    wait_hi(1, 1200);
    chk_pin("timeout reset", 1'b1, chip_rst_req);
    do_reset();
    rd_chk("flag set", OFF_RSTFLG, 32'h0000_0001);
    wr(OFF_RSTFLG, 32'h0000_0001);
    rd_chk("flag clear", OFF_RSTFLG, 32'h0000_0000);
    wr(OFF_MODE, 32'h0000_0003);
    wr(OFF_FEED, 32'h0000_0012);
    wait_hi(1, 4);
    chk_pin("feed reset", 1'b1, chip_rst_req);
    results();
  end
endmodule
